// *** vsc_seq.sv ***
// vsc_seq: sequencer end: index + five indexed registers, clock select,
// dot/character clock, serializer load, blanking, plane and font logic.
// assumes: vsc_bus_if dev modport, single clk_sys_i domain.
// Contract
// - index is 3 bits, upper read zero
// - orderly-halt bit 1 clears synchronously
// - immediate-halt bit 0 clears asynchronously; code clears run synchronously on the write edge
// - run only when both halt bits one
// - software halts before changing clock bits
// - forced blank keeps sync, frees bandwidth
// - load4 bit loads every fourth char
// - load2 bit loads every second char
// - halfdot bit divides master clock two
// - dot8 bit selects eight or nine dots
// - ninth dot copies eighth for C0-DF
// - plane mask enables per-plane writes
// - software keeps odd/even masks paired
// - font A code selects plane-2 segment
// - font B code same mapping
// - switch only bigmem and codes differ
// - chain4 low address selects plane
// - chain4 also steers read plane
// - odd/even address splits plane pairs
// - bigmem bit enables full memory
// - output register picks master clock
//
// Design decision made here: strobed register access.
`timescale 1ns/10ps
module vsc_seq (
   input  wire logic        clk_sys_i,
   input  wire logic        reset_n_i,
   vsc_bus_if.dev           bus,
   input  wire logic [15:0] cpu_addr_i,
   input  wire logic        cpu_wr_i,
   input  wire logic        cpu_rd_i,
   input  wire logic [7:0]  char_code_i,
   input  wire logic        attr_b3_i,
   input  wire logic        dot8_i,
   output logic             run_o,
   output logic             dot_en_o,
   output logic             char_en_o,
   output logic             ser_load_o,
   output logic             blank_o,
   output logic             cpu_prio_o,
   output logic             dot9_o,
   output logic [3:0]       plane_we_o,
   output logic [1:0]       read_plane_o,
   output logic             plane_page_o,
   output logic [2:0]       font_seg_o,
   output logic             font_low16_o,
   output logic             big_mem_o,
   output logic [1:0]       clk_sel_o
);
   import vsc_pkg::*;

   typedef struct packed {
      logic [2:0] idx;
      logic [7:0] halt, clk, pmask, font, mem, outr, rdata;
      logic       hdiv;
      logic [3:0] dotcnt;
      logic [1:0] charcnt;
      logic       run, dot_en, char_en, ser_load, blank, prio, dot9;
      logic [3:0] we;
      logic [1:0] rplane;
      logic       page;
      logic [2:0] seg;
      logic       low16;
   } vsc_seq_s;

   vsc_seq_s st_reg, st_next;
   logic [3:0] dots_max;
   logic [2:0] code_a, code_b;
   logic       sw_ok;

   always_comb begin
      st_next = st_reg;
      if (bus.io_wr && bus.io_addr == VSC_PORT_INDEX)
         st_next.idx = bus.io_wdata[2:0];
      if (bus.io_wr && bus.io_addr == VSC_PORT_DATA) begin
         case (st_reg.idx)
            VSC_IDX_HALT:  st_next.halt  = bus.io_wdata & VSC_MSK_HALT;
            VSC_IDX_CLOCK: st_next.clk   = bus.io_wdata & VSC_MSK_CLOCK;
            VSC_IDX_PMASK: st_next.pmask = bus.io_wdata & VSC_MSK_PMASK;
            VSC_IDX_FONT:  st_next.font  = bus.io_wdata & VSC_MSK_FONT;
            VSC_IDX_MEM:   st_next.mem   = bus.io_wdata & VSC_MSK_MEM;
            default:       st_next.idx   = st_reg.idx;
         endcase
      end
      if (bus.io_wr && bus.io_addr == VSC_PORT_OUT_W)
         st_next.outr = bus.io_wdata & VSC_MSK_OUT;
      st_next.rdata = VSC_RST_VAL;
      if (bus.io_rd) begin
         if (bus.io_addr == VSC_PORT_INDEX)
            st_next.rdata = {5'h00, st_reg.idx};
         else if (bus.io_addr == VSC_PORT_OUT_R)
            st_next.rdata = st_reg.outr;
         else if (bus.io_addr == VSC_PORT_DATA) begin
            case (st_reg.idx)
               VSC_IDX_HALT:  st_next.rdata = st_reg.halt;
               VSC_IDX_CLOCK: st_next.rdata = st_reg.clk;
               VSC_IDX_PMASK: st_next.rdata = st_reg.pmask;
               VSC_IDX_FONT:  st_next.rdata = st_reg.font;
               VSC_IDX_MEM:   st_next.rdata = st_reg.mem;
               default:       st_next.rdata = VSC_RST_VAL;
            endcase
         end
      end
      // immediate bit stops on its write edge
      // no async clear from a register bit: glitch hazard
      st_next.run = st_reg.halt[VSC_B_ORDERLY] &
                    st_next.halt[VSC_B_IMMED];
      dots_max = st_reg.clk[VSC_B_DOT8] ? VSC_DOTS_8 : VSC_DOTS_9;
      st_next.dot_en = 1'b0;
      st_next.char_en = 1'b0;
      st_next.ser_load = 1'b0;
      if (!st_next.run) begin
         st_next.hdiv = 1'b0;
         st_next.dotcnt = 4'h0;
         st_next.charcnt = 2'h0;
      end else begin
         st_next.hdiv = st_reg.clk[VSC_B_HALFDOT] ? ~st_reg.hdiv : 1'b0;
         if (!st_reg.clk[VSC_B_HALFDOT] || st_reg.hdiv) begin
            st_next.dot_en = 1'b1;
            if (st_reg.dotcnt >= dots_max - 4'h1) begin
               st_next.dotcnt = 4'h0;
               st_next.char_en = 1'b1;
               st_next.charcnt = st_reg.charcnt + 2'h1;
               if (st_reg.clk[VSC_B_LOAD4])
                  st_next.ser_load = (st_reg.charcnt == 2'h3);
               else if (st_reg.clk[VSC_B_LOAD2])
                  st_next.ser_load = st_reg.charcnt[0];
               else
                  st_next.ser_load = 1'b1;
            end else
               st_next.dotcnt = st_reg.dotcnt + 4'h1;
         end
      end
      st_next.blank = st_reg.clk[VSC_B_BLANK] | ~st_next.run;
      st_next.prio = st_reg.clk[VSC_B_BLANK];
      st_next.dot9 = ~st_reg.clk[VSC_B_DOT8] & dot8_i &
                     char_code_i >= VSC_GLYPH_LO &&
                     char_code_i <= VSC_GLYPH_HI;
      st_next.we = 4'h0;
      st_next.page = 1'b0;
      if (cpu_wr_i) begin
         if (st_reg.mem[VSC_B_CHAIN4])
            st_next.we = st_reg.pmask[3:0] &
                         (4'h1 << cpu_addr_i[1:0]);
         else if (!st_reg.mem[VSC_B_SEQADDR])
            st_next.we = st_reg.pmask[3:0] &
                         (cpu_addr_i[0] ? 4'hA : 4'h5);
         else
            st_next.we = st_reg.pmask[3:0];
      end
      if (cpu_rd_i && st_reg.mem[VSC_B_CHAIN4])
         st_next.rplane = cpu_addr_i[1:0];
      if (!st_reg.mem[VSC_B_SEQADDR] && !st_reg.mem[VSC_B_CHAIN4])
         st_next.page = cpu_addr_i[0];
      code_a = {st_reg.font[VSC_B_FONTA_HI],
                st_reg.font[VSC_B_CSEL_LO +: 2]};
      code_b = {st_reg.font[VSC_B_FONTB_HI],
                st_reg.font[VSC_B_FONTB_LO +: 2]};
      sw_ok = st_reg.mem[VSC_B_BIGMEM] && (code_a != code_b);
      st_next.low16 = ~sw_ok;
      if (!sw_ok)
         st_next.seg = 3'h0;
      else if (attr_b3_i)
         st_next.seg = {code_a[1:0], code_a[2]};
      else
         st_next.seg = {code_b[1:0], code_b[2]};
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign bus.io_rdata = st_reg.rdata;
   assign bus.clk_sel  = st_reg.outr[VSC_B_CLKSEL +: 2];
   assign run_o        = st_reg.run;
   assign dot_en_o     = st_reg.dot_en;
   assign char_en_o    = st_reg.char_en;
   assign ser_load_o   = st_reg.ser_load;
   assign blank_o      = st_reg.blank;
   assign cpu_prio_o   = st_reg.prio;
   assign dot9_o       = st_reg.dot9;
   assign plane_we_o   = st_reg.we;
   assign read_plane_o = st_reg.rplane;
   assign plane_page_o = st_reg.page;
   assign font_seg_o   = st_reg.seg;
   assign font_low16_o = st_reg.low16;
   assign big_mem_o    = st_reg.mem[VSC_B_BIGMEM];
   assign clk_sel_o    = st_reg.outr[VSC_B_CLKSEL +: 2];
endmodule : vsc_seq

// *** vsc_pkg.sv ***
// vsc_pkg: shared constants for the video sequencer control block.
// assumes both ends import it; no timescale in packages.
package vsc_pkg;
   localparam logic [15:0] VSC_PORT_INDEX = 16'h03C4;
   localparam logic [15:0] VSC_PORT_DATA  = 16'h03C5;
   localparam logic [2:0]  VSC_IDX_HALT   = 3'h0;
   localparam logic [2:0]  VSC_IDX_CLOCK  = 3'h1;
   localparam logic [2:0]  VSC_IDX_PMASK  = 3'h2;
   localparam logic [2:0]  VSC_IDX_FONT   = 3'h3;
   localparam logic [2:0]  VSC_IDX_MEM    = 3'h4;
   // readback masks for reserved bits
   localparam logic [7:0]  VSC_MSK_INDEX  = 8'h07;
   localparam logic [7:0]  VSC_MSK_HALT   = 8'h03;
   localparam logic [7:0]  VSC_MSK_CLOCK  = 8'h3D;
   localparam logic [7:0]  VSC_MSK_PMASK  = 8'h0F;
   localparam logic [7:0]  VSC_MSK_FONT   = 8'h3F;
   localparam logic [7:0]  VSC_MSK_MEM    = 8'h0E;
   localparam logic [7:0]  VSC_MSK_OUT    = 8'h0C;
   // field positions
   localparam int VSC_B_ORDERLY  = 1;
   localparam int VSC_B_IMMED    = 0;
   localparam int VSC_B_BLANK    = 5;
   localparam int VSC_B_LOAD4    = 4;
   localparam int VSC_B_HALFDOT  = 3;
   localparam int VSC_B_LOAD2    = 2;
   localparam int VSC_B_DOT8     = 0;
   localparam int VSC_B_CHAIN4   = 3;
   localparam int VSC_B_SEQADDR  = 2;
   localparam int VSC_B_BIGMEM   = 1;
   localparam int VSC_B_CSEL_LO  = 2;
   // reset values (all zero after hardware reset)
   localparam logic [7:0]  VSC_RST_VAL    = 8'h00;
   localparam logic [7:0]  VSC_GLYPH_LO   = 8'hC0;
   localparam logic [7:0]  VSC_GLYPH_HI   = 8'hDF;
   localparam logic [3:0]  VSC_DOTS_9     = 4'h9;
   localparam logic [3:0]  VSC_DOTS_8     = 4'h8;
   localparam logic [3:0]  VSC_ALL_PLANES = 4'hF;
   localparam logic [1:0]  VSC_CLK_25     = 2'h0;
   localparam logic [1:0]  VSC_CLK_28     = 2'h1;
   localparam logic [1:0]  VSC_CLK_EXT    = 2'h2;
   localparam logic [1:0]  VSC_CLK_RSVD   = 2'h3;
   localparam logic [15:0] VSC_PORT_OUT_W = 16'h03C2;
   localparam logic [15:0] VSC_PORT_OUT_R = 16'h03CC;
   // halt values: orderly bit low first, then both high to run
   localparam logic [7:0]  VSC_HALT_ORDERLY = 8'h01;
   localparam logic [7:0]  VSC_HALT_RUN     = 8'h03;
   // font code fields and clock select field
   localparam int VSC_B_FONTA_HI = 5;
   localparam int VSC_B_FONTB_HI = 4;
   localparam int VSC_B_FONTB_LO = 0;
   localparam int VSC_B_CLKSEL   = 2;
endpackage : vsc_pkg

// *** vsc_bus_if.sv ***
// vsc_bus_if: processor i/o port between controller and sequencer.
// assumes one clock; read data valid the cycle after io_rd.
`timescale 1ns/10ps
interface vsc_bus_if;
   logic [15:0] io_addr;
   logic [7:0]  io_wdata;
   logic        io_wr;
   logic        io_rd;
   logic [7:0]  io_rdata;
   logic [1:0]  clk_sel;
   modport dev  (input io_addr, io_wdata, io_wr, io_rd, output io_rdata,
                 output clk_sel);
   modport host (output io_addr, io_wdata, io_wr, io_rd, input io_rdata,
                 input clk_sel);
endinterface : vsc_bus_if

// *** vsc_host.sv ***
// vsc_host: processor end; runs register writes/reads over the port.
// assumes user issues one command at a time while busy_o is low.
`timescale 1ns/10ps
module vsc_host (
   input  wire logic        clk_sys_i,
   input  wire logic        reset_n_i,
   vsc_bus_if.host          bus,
   input  wire logic        cmd_wr_i,
   input  wire logic        cmd_rd_i,
   input  wire logic        cmd_ext_i,
   input  wire logic [2:0]  cmd_idx_i,
   input  wire logic [7:0]  cmd_data_i,
   output logic             busy_o,
   output logic             done_o,
   output logic [7:0]       rdata_o
);
   import vsc_pkg::*;

   typedef enum logic [2:0] {
      S_IDLE, S_HALT, S_INDEX, S_DATA, S_RDWAIT, S_RESUME
   } vsc_host_e;

   typedef struct packed {
      vsc_host_e   st;
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr, rd, busy, done, isrd, ext;
      logic [2:0]  idx;
      logic [7:0]  data, rdata;
   } vsc_host_s;

   vsc_host_s h_reg, h_next;

   always_comb begin
      h_next = h_reg;
      h_next.wr = 1'b0;
      h_next.rd = 1'b0;
      h_next.done = 1'b0;
      case (h_reg.st)
         S_IDLE: begin
            if (cmd_wr_i || cmd_rd_i) begin
               h_next.isrd = cmd_rd_i;
               h_next.ext = cmd_ext_i;
               h_next.idx = cmd_idx_i;
               h_next.data = cmd_data_i;
               h_next.busy = 1'b1;
               if (cmd_wr_i && (cmd_ext_i || cmd_idx_i == VSC_IDX_CLOCK)) begin
                  h_next.wr = 1'b1;
                  h_next.addr = VSC_PORT_INDEX;
                  h_next.wdata = {5'h00, VSC_IDX_HALT};
                  h_next.st = S_HALT;
               end else if (cmd_rd_i && cmd_ext_i) begin
                  h_next.rd = 1'b1;
                  h_next.addr = VSC_PORT_OUT_R;
                  h_next.st = S_RDWAIT;
               end else begin
                  h_next.wr = 1'b1;
                  h_next.addr = VSC_PORT_INDEX;
                  h_next.wdata = {5'h00, cmd_idx_i};
                  h_next.st = S_DATA;
               end
            end
         end
         S_HALT: begin
            h_next.wr = 1'b1;
            h_next.addr = VSC_PORT_DATA;
            h_next.wdata = VSC_HALT_ORDERLY;
            h_next.st = S_INDEX;
         end
         S_INDEX: begin
            h_next.wr = 1'b1;
            h_next.addr = h_reg.ext ? VSC_PORT_OUT_W : VSC_PORT_INDEX;
            h_next.wdata = h_reg.ext ? h_reg.data : {5'h00, h_reg.idx};
            h_next.st = h_reg.ext ? S_RESUME : S_DATA;
         end
         S_DATA: begin
            h_next.addr = VSC_PORT_DATA;
            if (h_reg.isrd) begin
               h_next.rd = 1'b1;
               h_next.st = S_RDWAIT;
            end else begin
               h_next.wr = 1'b1;
               h_next.wdata = h_reg.data;
               h_next.st = (h_reg.idx == VSC_IDX_CLOCK) ? S_RESUME : S_IDLE;
               h_next.done = (h_reg.idx != VSC_IDX_CLOCK);
               h_next.busy = (h_reg.idx == VSC_IDX_CLOCK);
            end
         end
         S_RDWAIT: begin
            // data stands only in the cycle after the strobe
            if (!h_reg.rd) begin
               h_next.rdata = bus.io_rdata;
               h_next.done = 1'b1;
               h_next.busy = 1'b0;
               h_next.st = S_IDLE;
            end
         end
         S_RESUME: begin
            if (!h_reg.wr) begin
               // index back to halt register, then release
               h_next.wr = 1'b1;
               h_next.addr = VSC_PORT_INDEX;
               h_next.wdata = {5'h00, VSC_IDX_HALT};
            end else if (h_reg.addr == VSC_PORT_INDEX) begin
               h_next.wr = 1'b1;
               h_next.addr = VSC_PORT_DATA;
               h_next.wdata = VSC_HALT_RUN;
               h_next.done = 1'b1;
               h_next.busy = 1'b0;
               h_next.st = S_IDLE;
            end else begin
               h_next.wr = 1'b1;
               h_next.addr = VSC_PORT_INDEX;
               h_next.wdata = {5'h00, VSC_IDX_HALT};
            end
         end
         default: h_next.st = S_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         h_reg <= '0;
      end else begin
         h_reg <= h_next;
      end
   end

   assign bus.io_addr  = h_reg.addr;
   assign bus.io_wdata = h_reg.wdata;
   assign bus.io_wr    = h_reg.wr;
   assign bus.io_rd    = h_reg.rd;
   assign busy_o       = h_reg.busy;
   assign done_o       = h_reg.done;
   assign rdata_o      = h_reg.rdata;
endmodule : vsc_host

// *** vsc_props.sv ***
// vsc_props: assertions on the port joining host and sequencer ends.
// assumes one clock; shadow copies are rebuilt from observed writes.
`timescale 1ns/10ps
module vsc_props (
   input wire logic        clk_sys_i,
   input wire logic        reset_n_i,
   input wire logic [15:0] io_addr,
   input wire logic [7:0]  io_wdata,
   input wire logic        io_wr,
   input wire logic        io_rd,
   input wire logic [7:0]  io_rdata,
   input wire logic [1:0]  clk_sel
);
   import vsc_pkg::*;
   localparam logic [15:0] OUT_W = 16'h03C2;
   localparam logic [15:0] OUT_R = 16'h03CC;
   localparam logic [7:0]  MSK [0:4] = '{VSC_MSK_HALT, VSC_MSK_CLOCK,
      VSC_MSK_PMASK, VSC_MSK_FONT, VSC_MSK_MEM};
   logic [2:0] idx_reg;
   logic [1:0] out_reg;
   logic [7:0] sh_reg [0:4];
   logic       wr_data;
   logic       rd_data;
   logic       clk_change;
   assign wr_data = io_wr && io_addr == VSC_PORT_DATA;
   assign rd_data = io_rd && io_addr == VSC_PORT_DATA && idx_reg < 3'h5;
   assign clk_change = (wr_data && idx_reg == VSC_IDX_CLOCK
         && ((io_wdata ^ sh_reg[1]) & 8'h09) != 8'h00)
      || (io_wr && io_addr == OUT_W && io_wdata[3:2] != out_reg);
   // writes at index 5..7 leave the shadow alone
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         idx_reg <= 3'h0;
         out_reg <= 2'h0;
         for (int i = 0; i < 5; i++) sh_reg[i] <= 8'h00;
      end else begin
         if (io_wr && io_addr == VSC_PORT_INDEX) idx_reg <= io_wdata[2:0];
         if (wr_data && idx_reg < 3'h5)
            sh_reg[idx_reg] <= io_wdata & MSK[idx_reg];
         if (io_wr && io_addr == OUT_W) out_reg <= io_wdata[3:2];
      end
   end
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!reset_n_i);
   AST_IDX_READ: assert property (
      io_rd && io_addr == VSC_PORT_INDEX |=> io_rdata == {5'h00, idx_reg})
      else $error("index readback wrong");
   AST_DATA_READ: assert property (
      rd_data |=> io_rdata == sh_reg[idx_reg])
      else $error("data port readback wrong");
   AST_RD_IDLE: assert property (
      !io_rd |=> io_rdata == 8'h00)
      else $error("read data outside its cycle");
   AST_OUT_READ: assert property (
      io_rd && io_addr == OUT_R |=> io_rdata == {4'h0, out_reg, 2'h0})
      else $error("output register readback wrong");
   AST_CLKSEL: assert property (
      clk_sel == out_reg)
      else $error("clock select differs from output register");
   AST_CLKSEL_HOLD: assert property (
      !(io_wr && io_addr == OUT_W) |=> $stable(clk_sel))
      else $error("clock select moved without a write");
   AST_HALT_FIRST: assert property (
      clk_change |-> !sh_reg[0][1])
      else $error("clock bits changed while running");
   AST_STROBE_EXCL: assert property (
      !(io_wr && io_rd))
      else $error("write and read strobes together");
endmodule : vsc_props

// *** testbench.sv ***
// testbench: host and sequencer ends joined over the port interface.
// assumes vsc_pkg, vsc_bus_if, vsc_seq, vsc_host, vsc_props compiled.
`timescale 1ns/10ps
module testbench;
   import vsc_pkg::*;
   typedef struct packed {
      logic       ext;
      logic [2:0] idx;
      logic [7:0] wd;
      logic [7:0] exp;
   } vsc_row_s;
   // clock rows first: the host halts before each one and writes halt 03 after it
   localparam vsc_row_s ROWS [0:9] = '{
      '{1'b1, 3'h0, 8'hFF, 8'h0C}, '{1'b1, 3'h0, 8'h08, 8'h08},
      '{1'b1, 3'h0, 8'h04, 8'h04}, '{1'b1, 3'h0, 8'h00, 8'h00},
      '{1'b0, 3'h1, 8'hFF, 8'h3D}, '{1'b0, 3'h1, 8'h00, 8'h00},
      '{1'b0, 3'h2, 8'hFF, 8'h0F}, '{1'b0, 3'h3, 8'hFF, 8'h3F},
      '{1'b0, 3'h4, 8'hFF, 8'h0E}, '{1'b0, 3'h0, 8'hFF, 8'h03}};
   localparam logic [7:0] CFG [0:5] = '{8'h01, 8'h04, 8'h10, 8'h08,
      8'h09, 8'h00};
   logic        clk_sys_i, reset_n_i, cmd_wr, cmd_rd, cmd_ext, busy, done;
   logic        cpu_wr, cpu_rd, attr_b3, dot8, run, dot_en, char_en;
   logic        ser_load, blank, cpu_prio, dot9, page, low16, big_mem;
   logic [2:0]  cmd_idx, font_seg;
   logic [7:0]  cmd_data, rdata, char_code, rd_val;
   logic [15:0] cpu_addr;
   logic [3:0]  plane_we;
   logic [1:0]  read_plane, clk_sel;
   int          n_fail, checks, dc, cc, lc, e, i;
   vsc_bus_if vsc_bus_if_i ();
   vsc_seq vsc_seq_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
      .bus(vsc_bus_if_i), .cpu_addr_i(cpu_addr), .cpu_wr_i(cpu_wr),
      .cpu_rd_i(cpu_rd), .char_code_i(char_code), .attr_b3_i(attr_b3),
      .dot8_i(dot8), .run_o(run), .dot_en_o(dot_en), .char_en_o(char_en),
      .ser_load_o(ser_load), .blank_o(blank), .cpu_prio_o(cpu_prio),
      .dot9_o(dot9), .plane_we_o(plane_we), .read_plane_o(read_plane),
      .plane_page_o(page), .font_seg_o(font_seg), .font_low16_o(low16),
      .big_mem_o(big_mem), .clk_sel_o(clk_sel));
   vsc_host vsc_host_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
      .bus(vsc_bus_if_i), .cmd_wr_i(cmd_wr), .cmd_rd_i(cmd_rd),
      .cmd_ext_i(cmd_ext), .cmd_idx_i(cmd_idx), .cmd_data_i(cmd_data),
      .busy_o(busy), .done_o(done), .rdata_o(rdata));
   vsc_props vsc_props_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
      .io_addr(vsc_bus_if_i.io_addr), .io_wdata(vsc_bus_if_i.io_wdata),
      .io_wr(vsc_bus_if_i.io_wr), .io_rd(vsc_bus_if_i.io_rd),
      .io_rdata(vsc_bus_if_i.io_rdata), .clk_sel(vsc_bus_if_i.clk_sel));
   always #50 clk_sys_i = ~clk_sys_i;
   task close_out;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // counts drift by one with the divider phase
   task near(input int got, input int exp);
      checks++;
      if (got > exp + 1 || got + 1 < exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : near
   task cmd(input logic w, input logic x, input logic [2:0] ix,
            input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      cmd_wr   <= w;
      cmd_rd   <= !w;
      cmd_ext  <= x;
      cmd_idx  <= ix;
      cmd_data <= d;
      @(posedge clk_sys_i);
      cmd_wr <= 1'b0;
      cmd_rd <= 1'b0;
      do begin
         @(posedge clk_sys_i);
         #1;
         n++;
      end while (done !== 1'b1 && n < 20);
      rd_val = rdata;
      if (done !== 1'b1) begin
         chk(done, 1'b1);
         close_out();
      end
      repeat (2) @(posedge clk_sys_i);
      #1;
   endtask : cmd
   task count(input int n);
      dc = 0;
      cc = 0;
      lc = 0;
      repeat (n) begin
         @(posedge clk_sys_i);
         #1;
         dc += dot_en;
         cc += char_en;
         lc += ser_load;
         // unknown strobes would read as zero in an int
         if ($isunknown({dot_en, char_en, ser_load})) dc = -1000;
      end
   endtask : count
   task mem_cyc(input logic [15:0] a, input logic w);
      @(posedge clk_sys_i);
      cpu_addr <= a;
      cpu_wr   <= w;
      cpu_rd   <= !w;
      repeat (2) @(posedge clk_sys_i);
      #1;
   endtask : mem_cyc
   task d9(input logic [7:0] c, input logic b, input logic ex);
      @(posedge clk_sys_i);
      char_code <= c;
      dot8      <= b;
      repeat (3) @(posedge clk_sys_i);
      #1;
      chk(dot9, ex);
   endtask : d9
   initial begin
      {clk_sys_i, reset_n_i, cmd_wr, cmd_rd, cmd_ext, cpu_wr} = '0;
      {cpu_rd, attr_b3, dot8, cmd_idx, cmd_data, char_code} = '0;
      cpu_addr = 16'h0000;
      n_fail = 0;
      checks = 0;
      repeat (16) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      for (i = 0; i < 10; i++) begin
         cmd(1'b1, ROWS[i].ext, ROWS[i].idx, ROWS[i].wd);
         cmd(1'b0, ROWS[i].ext, ROWS[i].idx, 8'h00);
         chk(rd_val, ROWS[i].exp);
         if (ROWS[i].ext) chk(clk_sel, ROWS[i].exp[3:2]);
      end
      $display("register rows done");
      for (i = 0; i < 6; i++) begin
         cmd(1'b1, 1'b0, VSC_IDX_HALT, 8'h01);
         chk(run, 1'b0);
         cmd(1'b1, 1'b0, VSC_IDX_CLOCK, CFG[i]);
         cmd(1'b1, 1'b0, VSC_IDX_HALT, 8'h03);
         chk(run, 1'b1);
         chk(blank, 1'b0);
         count(720);
         e = (CFG[i][3] ? 360 : 720) / (CFG[i][0] ? 8 : 9);
         near(dc, CFG[i][3] ? 360 : 720);
         near(cc, e);
         near(lc, CFG[i][4] ? e / 4 :
              CFG[i][2] ? e / 2 : e);
      end
      $display("clocking done");
      cmd(1'b1, 1'b0, VSC_IDX_CLOCK, 8'h20);
      chk({blank, cpu_prio}, 2'h3);
      cmd(1'b1, 1'b0, VSC_IDX_CLOCK, 8'h00);
      d9(8'hC0, 1'b1, 1'b1);
      d9(8'hDF, 1'b0, 1'b0);
      d9(8'hDF, 1'b1, 1'b1);
      d9(8'hE0, 1'b1, 1'b0);
      $display("blank and ninth dot done");
      cmd(1'b1, 1'b0, VSC_IDX_PMASK, 8'h0F);
      cmd(1'b1, 1'b0, VSC_IDX_MEM, 8'h08);
      for (i = 0; i < 4; i++) begin
         mem_cyc(16'(i), 1'b1);
         chk(plane_we, 16'h0001 << i);
         mem_cyc(16'(i), 1'b0);
         chk(read_plane, 16'(i));
      end
      mem_cyc(16'h0002, 1'b1);
      cmd(1'b1, 1'b0, VSC_IDX_MEM, 8'h00);
      chk(plane_we, 16'h0005);
      chk(page, 1'b0);
      mem_cyc(16'h0003, 1'b1);
      chk(plane_we, 16'h000A);
      chk(page, 1'b1);
      // sequential mode first, pairs never split
      cmd(1'b1, 1'b0, VSC_IDX_MEM, 8'h04);
      cmd(1'b1, 1'b0, VSC_IDX_PMASK, 8'h05);
      chk(plane_we, 16'h0005);
      cpu_wr <= 1'b0;
      cpu_rd <= 1'b0;
      $display("planes done");
      cmd(1'b1, 1'b0, VSC_IDX_FONT, 8'h24);
      cmd(1'b1, 1'b0, VSC_IDX_MEM, 8'h02);
      attr_b3 <= 1'b1;
      mem_cyc(16'h0000, 1'b0);
      chk({big_mem, low16, font_seg}, 16'h0013);
      attr_b3 <= 1'b0;
      mem_cyc(16'h0000, 1'b0);
      chk({low16, font_seg}, 16'h0000);
      cmd(1'b1, 1'b0, VSC_IDX_MEM, 8'h00);
      chk({big_mem, low16}, 16'h0001);
      $display("fonts done");
      cmd(1'b1, 1'b0, 3'h5, 8'hFF);
      cmd(1'b0, 1'b0, 3'h5, 8'h00);
      chk(rd_val, 8'h00);
      cmd(1'b0, 1'b0, VSC_IDX_PMASK, 8'h00);
      chk(rd_val, 8'h05);
      cmd(1'b1, 1'b0, VSC_IDX_HALT, 8'h02);
      chk(run, 1'b0);
      count(100);
      chk(16'(cc), 16'h0000);
      cmd(1'b1, 1'b0, VSC_IDX_HALT, 8'h03);
      reset_n_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      @(posedge clk_sys_i);
      #1;
      chk({run, blank}, 2'h1);
      cmd(1'b0, 1'b0, VSC_IDX_HALT, 8'h00);
      chk(rd_val, 8'h00);
      $display("halt and reset done");
      close_out();
   end
endmodule : testbench
